// file: pkg/rrm_pkg.sv
// constants, field layout and carrier types of the runtime register map
package rrm_pkg;

  typedef logic [7:0] rrm_byte_t;
  typedef logic [7:0] rrm_idx_t;

  // register indices; byte address on the bus is four times the index
  localparam rrm_idx_t IDX_GPIO_DATA_TWO        = 8'h4c;
  localparam rrm_idx_t IDX_GPIO_DATA_THREE      = 8'h4d;
  localparam rrm_idx_t IDX_GPIO_DATA_FOUR       = 8'h4e;
  localparam rrm_idx_t IDX_GPIO_DATA_FIVE       = 8'h4f;
  localparam rrm_idx_t IDX_GPIO_DATA_SIX        = 8'h50;
  localparam rrm_idx_t IDX_WATCHDOG_TIME_UNITS  = 8'h52;
  localparam rrm_idx_t IDX_WATCHDOG_COUNT_VALUE = 8'h53;
  localparam rrm_idx_t IDX_WATCHDOG_CONFIG      = 8'h54;
  localparam rrm_idx_t IDX_WATCHDOG_CONTROL     = 8'h55;
  localparam rrm_idx_t IDX_FAN_PIN_CONFIG       = 8'h56;
  localparam rrm_idx_t IDX_FAN_SPEED_CONTROL    = 8'h58;
  localparam rrm_idx_t IDX_FAN_TACH_COUNT       = 8'h59;
  localparam rrm_idx_t IDX_FAN_COUNT_PRELOAD    = 8'h5b;
  localparam rrm_idx_t IDX_INDICATOR_ONE        = 8'h5d;
  localparam rrm_idx_t IDX_INDICATOR_TWO        = 8'h5e;
  localparam rrm_idx_t IDX_WAKE_KEY_CODE        = 8'h5f;
  localparam rrm_idx_t IDX_POWER_MGMT_ONE       = 8'h60;
  localparam rrm_idx_t IDX_POWER_MGMT_TWO       = 8'h61;
  localparam rrm_idx_t IDX_MGMT_IRQ_STATUS      = 8'h64;
  localparam rrm_idx_t IDX_MGMT_IRQ_ENABLE      = 8'h66;
  localparam rrm_idx_t IDX_WAKE_EVENT_STATUS    = 8'h68;
  localparam rrm_idx_t IDX_WAKE_EVENT_ENABLE    = 8'h6c;
  localparam rrm_idx_t IDX_PIN43_CONFIG         = 8'h80;
  localparam rrm_idx_t IDX_FUNCTION_DISABLE     = 8'h81;
  localparam rrm_idx_t IDX_PORT_CONTROL         = 8'h82;
  localparam rrm_idx_t IDX_EVENT_STATUS         = 8'h83;
  localparam rrm_idx_t IDX_EVENT_MASK           = 8'h84;
  localparam rrm_idx_t IDX_NONE                 = 8'hff;

  // reset values
  localparam rrm_byte_t RST_ZERO          = 8'h00;
  localparam rrm_byte_t RST_FAN_SPEED     = 8'h10;
  localparam rrm_byte_t RST_INDICATOR_TWO = 8'h01;

  // field positions
  localparam int unsigned GPIO3_FAN_BIT     = 3;
  localparam int unsigned P43_MODE_HI       = 3;
  localparam int unsigned P43_MODE_LO       = 2;
  localparam logic [1:0]  P43_MODE_LOCK     = 2'h1;
  localparam int unsigned FDIS_LOCK_BIT     = 1;
  localparam int unsigned WDT_KEEP_BIT      = 0;
  localparam int unsigned WDT_STATUS_BIT    = 6;
  localparam int unsigned WDT_KICK_BIT      = 7;
  localparam rrm_byte_t   WDT_RW_MASK       = 8'h3f;
  localparam int unsigned PCTL_ACTIVATE_BIT = 0;
  localparam int unsigned EV_FDIS_REFUSED   = 0;
  localparam int unsigned EV_HARD_RESET     = 1;
  localparam int unsigned EV_MAIN_POR       = 2;
  localparam int unsigned EV_ACK_FALL       = 3;
  localparam rrm_byte_t   EV_MASK           = 8'h0f;

  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;

  typedef struct packed {
    logic      req;
    rrm_idx_t  idx;
    rrm_byte_t data;
  } rrm_wr_s;

  typedef struct packed {
    logic     req;
    rrm_idx_t idx;
  } rrm_rd_s;

endpackage

// file: sim/rrm_regbank_monitor.sv
// port assertions for the runtime register bank
`timescale 1ns/1ps
module rrm_regbank_monitor
  import rrm_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        printer_acknowledge_in,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        irq,
  input wire logic        parallel_port_irq,
  input wire logic [7:0]  function_disable,
  input wire logic [7:0]  fan_speed_control,
  input wire logic        watchdog_kick
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_state: assert property ($rose(aresetn) |-> parallel_port_irq && !irq && !watchdog_kick
    && fan_speed_control == 8'h10 && function_disable == 8'h00) else $error("outputs wrong after reset");
  chk_port_follow: assert property (!parallel_port_irq |-> !$past(printer_acknowledge_in))
    else $error("port interrupt low without low acknowledge");
  chk_wr_okay: assert property (bvalid |-> bresp == AXI_RESP_OKAY)
    else $error("write response not okay");
  chk_rd_okay: assert property (rvalid |-> rresp == AXI_RESP_OKAY && rdata[31:8] == 24'h0)
    else $error("read response or upper data wrong");
  chk_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  chk_wr_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  chk_ar_block: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  chk_kick_pulse: assert property (watchdog_kick |=> !watchdog_kick)
    else $error("kick longer than one cycle");
endmodule // rrm_regbank_monitor

bind rrm_regbank rrm_regbank_monitor rrm_regbank_monitor_i (.aclk, .aresetn, .printer_acknowledge_in,
  .awready, .wready, .bresp, .bvalid, .bready, .arready, .rdata, .rresp, .rvalid, .rready, .irq,
  .parallel_port_irq, .function_disable, .fan_speed_control, .watchdog_kick);

// file: sim/testbench.sv
// self-checking bench for the runtime register bank
`timescale 1ns/1ps
module testbench
  import rrm_pkg::*;
;
  logic        aclk, aresetn, main_por, hard_reset, pin_forty_three_level, printer_acknowledge_in;
  logic        watchdog_expired_in, awvalid, wvalid, bready, arvalid, rready, prev;
  logic        awready, wready, bvalid, arready, rvalid, irq, parallel_port_irq, watchdog_kick;
  logic [7:0]  fan_tach_in, function_disable, fan_speed_control;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, r;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  rrm_byte_t   mem [256];
  rrm_byte_t   expq [$];
  int          err_count, comparisons, kicks, k;
  rrm_byte_t   fd_c [4] = '{8'h08, 8'h04, 8'h04, 8'h00};
  logic        fd_p [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  rrm_byte_t   fd_w [4] = '{8'h01, 8'h10, 8'h02, 8'h00};
  rrm_byte_t   fd_e [4] = '{8'h01, 8'h01, 8'h02, 8'h02};
  rrm_idx_t    ev_a [4] = '{IDX_EVENT_MASK, IDX_EVENT_STATUS, IDX_EVENT_MASK, IDX_EVENT_STATUS};
  rrm_byte_t   ev_d [4] = '{8'h04, 8'h04, 8'h0f, 8'h0f};

  rrm_regbank rrm_regbank_i (.aclk, .aresetn, .main_por, .hard_reset, .pin_forty_three_level,
    .printer_acknowledge_in, .watchdog_expired_in, .fan_tach_in, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .irq, .parallel_port_irq, .function_disable, .fan_speed_control, .watchdog_kick);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [11:0] ad(input rrm_idx_t i);
    return {2'b00, i, 2'b00};
  endfunction

  // expected read-back of a bank offset holding v
  function automatic rrm_byte_t want(input rrm_idx_t i, input rrm_byte_t v);
    case (i)
      8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h52, 8'h53, 8'h54, 8'h56, 8'h58, 8'h5b,
      8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h64, 8'h66, 8'h68, 8'h6c: return v;
      8'h55: return (v & WDT_RW_MASK) | {1'b0, watchdog_expired_in, 6'h0};
      8'h59: return fan_tach_in;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string n, input rrm_byte_t e, input rrm_byte_t g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // upper data bits are random: only the low byte may count
  task automatic wr(input logic [11:0] a, input rrm_byte_t d);
    logic ta, tw, sa, sw;
    {ta, tw} = 2'b00;
    @(posedge aclk);
    r = rnd();
    awaddr <= a;
    wdata <= {r[31:8], d};
    // lane 0 carries the register byte; the other lanes are don't-care noise
    wstrb <= {r[3:1], 1'b1};
    {awvalid, wvalid} <= 2'b11;
    while (!(ta && tw))
    begin
      @(negedge aclk);
      sa = awvalid && awready;
      sw = wvalid && wready;
      @(posedge aclk);
      ta |= sa;
      tw |= sw;
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input rrm_byte_t e);
    logic s;
    expq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      s = arready;
      @(posedge aclk);
    end while (!s);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  always @(posedge aclk)
    if (rvalid && rready)
      chk("rdata", expq.pop_front(), rdata[7:0]);

  always @(posedge aclk)
    if (watchdog_kick)
      kicks++;

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    $display("BAD watchdog expected finish seen hang");
    report_and_stop();
  end

  initial
  begin
    {main_por, hard_reset, pin_forty_three_level, awvalid, wvalid, bready, arvalid, rready} = '0;
    {aresetn, awaddr, araddr, wdata, wstrb, fan_tach_in} = '0;
    {printer_acknowledge_in, watchdog_expired_in} = 2'b11;
    {err_count, comparisons, kicks} = '0;
    seed = 32'h665e;
    foreach (mem[j]) mem[j] = 8'h00;
    {mem[8'h58], mem[8'h5e]} = {RST_FAN_SPEED, RST_INDICATOR_TWO};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    r = rnd();
    fan_tach_in <= r[7:0];
    for (rrm_idx_t i = 8'h4c; i < 8'h80; i++) rd(ad(i), want(i, mem[i]));
    $display("test reset values done");
    for (rrm_idx_t i = 8'h4c; i < 8'h80; i++)
    begin
      r = rnd();
      mem[i] = r[7:0];
      wr(ad(i), mem[i]);
    end
    wr(12'hc00, 8'hff);
    chk("fan_speed_control", mem[8'h58], fan_speed_control);
    k = kicks;
    wr(ad(8'h55), 8'hc1);
    mem[8'h55] = 8'hc1;
    // drop the expiry level so the live status bit is seen at both levels
    watchdog_expired_in <= 1'b0;
    @(negedge aclk);
    chk("kicks", 8'(k + 1), 8'(kicks));
    for (rrm_idx_t i = 8'h4c; i < 8'h80; i++) rd(ad(i), want(i, mem[i]));
    rd(12'hc00, 8'h00);
    watchdog_expired_in <= 1'b1;
    $display("test write and read back done");
    for (int m = 0; m < 2; m++)
    begin
      wr(ad(8'h52), 8'h5a);
      wr(ad(8'h55), 8'h01);
      wr(ad(8'h4d), 8'hff);
      wr(ad(IDX_PIN43_CONFIG), 8'h0c);
      @(posedge aclk);
      hard_reset <= (m == 0);
      main_por <= (m == 1);
      @(posedge aclk);
      {hard_reset, main_por} <= 2'b00;
      rd(ad(8'h52), 8'h00);
      rd(ad(8'h55), m == 0 ? 8'h41 : 8'h40);
      rd(ad(8'h4d), 8'hf7);
      rd(ad(IDX_PIN43_CONFIG), 8'h00);
      rd(ad(8'h4c), mem[8'h4c]);
    end
    $display("test reset domains done");
    rd(ad(IDX_EVENT_STATUS), 8'h06);
    foreach (ev_a[j])
    begin
      wr(ad(ev_a[j]), ev_d[j]);
      @(negedge aclk);
      chk("irq", 8'(j % 2 == 0), 8'(irq));
    end
    $display("test interrupt done");
    foreach (fd_w[j])
    begin
      wr(ad(IDX_PIN43_CONFIG), fd_c[j]);
      pin_forty_three_level <= fd_p[j];
      wr(ad(IDX_FUNCTION_DISABLE), fd_w[j]);
      @(negedge aclk);
      chk("function_disable", fd_e[j], function_disable);
    end
    rd(ad(IDX_FUNCTION_DISABLE), 8'h02);
    rd(ad(IDX_EVENT_STATUS), 8'h01);
    $display("test disable lock done");
    printer_acknowledge_in <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("parallel_port_irq", 8'h01, 8'(parallel_port_irq));
    wr(ad(IDX_PORT_CONTROL), 8'h01);
    repeat (40)
    begin
      prev = printer_acknowledge_in;
      @(posedge aclk);
      r = rnd();
      printer_acknowledge_in <= r[0];
      @(negedge aclk);
      chk("parallel_port_irq", 8'(prev), 8'(parallel_port_irq));
    end
    printer_acknowledge_in <= 1'b0;
    wr(ad(IDX_PORT_CONTROL), 8'h00);
    @(negedge aclk);
    chk("parallel_port_irq", 8'h01, 8'(parallel_port_irq));
    $display("test port interrupt done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("fan_speed_control", RST_FAN_SPEED, fan_speed_control);
    chk("function_disable", 8'h00, function_disable);
    rd(ad(8'h4c), 8'h00);
    repeat (4) @(posedge aclk);
    chk("pending reads", 8'h00, 8'(expq.size()));
    $display("test second reset done");
    report_and_stop();
  end
endmodule // testbench

// file: verilog/rrm_axil_slave.sv
// axi4-lite slave front end that turns bus transfers into register strobes
`timescale 1ns/1ps
module rrm_axil_slave
  import rrm_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output rrm_wr_s                wr,
  output rrm_rd_s                rd,
  input  wire rrm_byte_t         rd_data
);

  typedef struct packed {
    logic      aw_held;
    rrm_idx_t  aw_idx;
    logic      w_held;
    rrm_byte_t w_data;
    logic      w_lane;
    logic      bvalid;
    logic      rvalid;
    rrm_byte_t rdata;
  } rrm_axi_st_s;

  rrm_axi_st_s s;
  rrm_axi_st_s next_s;

  // addresses beyond the decoded window map to no register
  function automatic rrm_idx_t idx_of(input logic [ADDR_W-1:0] a);
    idx_of = (|a[ADDR_W-1:10]) ? IDX_NONE : a[9:2];
  endfunction

  always_comb
  begin
    next_s  = s;
    wr      = '0;
    rd      = '0;
    awready = !s.aw_held && !s.bvalid;
    wready  = !s.w_held && !s.bvalid;
    arready = !s.rvalid;
    if (awvalid && awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx  = idx_of(awaddr);
    end
    if (wvalid && wready)
    begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata[7:0];
      next_s.w_lane = wstrb[0];
    end
    // data lives in byte lane 0; a write without that lane changes nothing
    if (s.aw_held && s.w_held)
    begin
      wr.req         = s.w_lane;
      wr.idx         = s.aw_idx;
      wr.data        = s.w_data;
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (arvalid && arready)
    begin
      rd.req        = 1'b1;
      rd.idx        = idx_of(araddr);
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_data;
    end
    if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign bvalid = s.bvalid;
  assign bresp  = AXI_RESP_OKAY;
  assign rvalid = s.rvalid;
  assign rresp  = AXI_RESP_OKAY;
  assign rdata  = {24'h0, s.rdata};

endmodule // rrm_axil_slave

// file: verilog/rrm_regbank.sv
// upper runtime register bank with reset domains, lockout and port interrupt
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module rrm_regbank
  import rrm_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              main_por,
  input  wire logic              hard_reset,
  input  wire logic              pin_forty_three_level,
  input  wire logic              printer_acknowledge_in,
  input  wire logic              watchdog_expired_in,
  input  wire logic [7:0]        fan_tach_in,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq,
  output logic                   parallel_port_irq,
  output logic [7:0]             function_disable,
  output logic [7:0]             fan_speed_control,
  output logic                   watchdog_kick
);

  typedef struct packed {
    rrm_byte_t gpio_data_two;
    rrm_byte_t gpio_data_three;
    rrm_byte_t gpio_data_four;
    rrm_byte_t gpio_data_five;
    rrm_byte_t gpio_data_six;
    rrm_byte_t watchdog_time_units;
    rrm_byte_t watchdog_count_value;
    rrm_byte_t watchdog_config;
    rrm_byte_t watchdog_control;
    rrm_byte_t fan_pin_config;
    rrm_byte_t fan_speed_control;
    rrm_byte_t fan_tach_count;
    rrm_byte_t fan_count_preload;
    rrm_byte_t indicator_one_control;
    rrm_byte_t indicator_two_control;
    rrm_byte_t wake_key_code;
    rrm_byte_t power_mgmt_control_one;
    rrm_byte_t power_mgmt_control_two;
    rrm_byte_t mgmt_irq_status_seven;
    rrm_byte_t mgmt_irq_enable_seven;
    rrm_byte_t wake_event_status_seven;
    rrm_byte_t wake_event_enable_seven;
    rrm_byte_t pin_forty_three_config;
    rrm_byte_t function_disable;
    rrm_byte_t port_control;
    rrm_byte_t event_status;
    rrm_byte_t event_mask;
    logic      port_irq;
    logic      ack_prev;
    logic      kick;
  } rrm_bank_st_s;

  rrm_bank_st_s s;
  rrm_bank_st_s next_s;
  rrm_wr_s      wr;
  rrm_rd_s      rd;
  rrm_byte_t    rd_data;
  logic         fdis_locked;
  rrm_byte_t    ev_set;
  rrm_byte_t    ev_clr;

  rrm_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr      (wr),
    .rd      (rd),
    .rd_data (rd_data)
  );

  // read view of the bank; anything not listed falls through to zero
  function automatic rrm_byte_t read_reg(input rrm_idx_t idx, input rrm_bank_st_s st, input logic wdt_status);
    read_reg = RST_ZERO;
    case (idx)
      IDX_GPIO_DATA_TWO:        read_reg = st.gpio_data_two;
      IDX_GPIO_DATA_THREE:      read_reg = st.gpio_data_three;
      IDX_GPIO_DATA_FOUR:       read_reg = st.gpio_data_four;
      IDX_GPIO_DATA_FIVE:       read_reg = st.gpio_data_five;
      IDX_GPIO_DATA_SIX:        read_reg = st.gpio_data_six;
      IDX_WATCHDOG_TIME_UNITS:  read_reg = st.watchdog_time_units;
      IDX_WATCHDOG_COUNT_VALUE: read_reg = st.watchdog_count_value;
      IDX_WATCHDOG_CONFIG:      read_reg = st.watchdog_config;
      IDX_WATCHDOG_CONTROL:
      begin
        // kick bit is write-only and reads zero; status bit is live
        read_reg                 = st.watchdog_control & WDT_RW_MASK;
        read_reg[WDT_STATUS_BIT] = wdt_status;
      end
      IDX_FAN_PIN_CONFIG:       read_reg = st.fan_pin_config;
      IDX_FAN_SPEED_CONTROL:    read_reg = st.fan_speed_control;
      IDX_FAN_TACH_COUNT:       read_reg = st.fan_tach_count;
      IDX_FAN_COUNT_PRELOAD:    read_reg = st.fan_count_preload;
      IDX_INDICATOR_ONE:        read_reg = st.indicator_one_control;
      IDX_INDICATOR_TWO:        read_reg = st.indicator_two_control;
      IDX_WAKE_KEY_CODE:        read_reg = st.wake_key_code;
      IDX_POWER_MGMT_ONE:       read_reg = st.power_mgmt_control_one;
      IDX_POWER_MGMT_TWO:       read_reg = st.power_mgmt_control_two;
      IDX_MGMT_IRQ_STATUS:      read_reg = st.mgmt_irq_status_seven;
      IDX_MGMT_IRQ_ENABLE:      read_reg = st.mgmt_irq_enable_seven;
      IDX_WAKE_EVENT_STATUS:    read_reg = st.wake_event_status_seven;
      IDX_WAKE_EVENT_ENABLE:    read_reg = st.wake_event_enable_seven;
      IDX_PIN43_CONFIG:         read_reg = st.pin_forty_three_config;
      IDX_FUNCTION_DISABLE:     read_reg = st.function_disable;
      IDX_PORT_CONTROL:         read_reg = st.port_control;
      IDX_EVENT_STATUS:         read_reg = st.event_status & EV_MASK;
      IDX_EVENT_MASK:           read_reg = st.event_mask & EV_MASK;
      default:                  read_reg = RST_ZERO;
    endcase
  endfunction

  // standby power-on reset image of every register
  function automatic rrm_bank_st_s standby_image();
    standby_image                       = '0;
    standby_image.fan_speed_control     = RST_FAN_SPEED;
    standby_image.indicator_two_control = RST_INDICATOR_TWO;
    standby_image.port_irq              = 1'b1;
    standby_image.ack_prev              = 1'b1;
  endfunction

  always_comb
  begin
    next_s  = s;
    ev_set  = RST_ZERO;
    ev_clr  = RST_ZERO;
    rd_data = read_reg(rd.idx, s, watchdog_expired_in);

    // lockout is evaluated from stored state and the pin level of this cycle
    fdis_locked = s.function_disable[FDIS_LOCK_BIT] ||
                  (s.pin_forty_three_config[P43_MODE_HI:P43_MODE_LO] == P43_MODE_LOCK &&
                   pin_forty_three_level);

    next_s.fan_tach_count = fan_tach_in;
    next_s.kick           = 1'b0;

    if (wr.req)
    begin
      case (wr.idx)
        IDX_GPIO_DATA_TWO:        next_s.gpio_data_two           = wr.data;
        IDX_GPIO_DATA_THREE:      next_s.gpio_data_three         = wr.data;
        IDX_GPIO_DATA_FOUR:       next_s.gpio_data_four          = wr.data;
        IDX_GPIO_DATA_FIVE:       next_s.gpio_data_five          = wr.data;
        IDX_GPIO_DATA_SIX:        next_s.gpio_data_six           = wr.data;
        IDX_WATCHDOG_TIME_UNITS:  next_s.watchdog_time_units     = wr.data;
        IDX_WATCHDOG_COUNT_VALUE: next_s.watchdog_count_value    = wr.data;
        IDX_WATCHDOG_CONFIG:      next_s.watchdog_config         = wr.data;
        IDX_WATCHDOG_CONTROL:
        begin
          // status bit is never stored; kick bit only makes a pulse
          next_s.watchdog_control = wr.data & WDT_RW_MASK;
          next_s.kick             = wr.data[WDT_KICK_BIT];
        end
        IDX_FAN_PIN_CONFIG:       next_s.fan_pin_config          = wr.data;
        IDX_FAN_SPEED_CONTROL:    next_s.fan_speed_control       = wr.data;
        IDX_FAN_COUNT_PRELOAD:    next_s.fan_count_preload       = wr.data;
        IDX_INDICATOR_ONE:        next_s.indicator_one_control   = wr.data;
        IDX_INDICATOR_TWO:        next_s.indicator_two_control   = wr.data;
        IDX_WAKE_KEY_CODE:        next_s.wake_key_code           = wr.data;
        IDX_POWER_MGMT_ONE:       next_s.power_mgmt_control_one  = wr.data;
        IDX_POWER_MGMT_TWO:       next_s.power_mgmt_control_two  = wr.data;
        IDX_MGMT_IRQ_STATUS:      next_s.mgmt_irq_status_seven   = wr.data;
        IDX_MGMT_IRQ_ENABLE:      next_s.mgmt_irq_enable_seven   = wr.data;
        IDX_WAKE_EVENT_STATUS:    next_s.wake_event_status_seven = wr.data;
        IDX_WAKE_EVENT_ENABLE:    next_s.wake_event_enable_seven = wr.data;
        IDX_PIN43_CONFIG:         next_s.pin_forty_three_config  = wr.data;
        IDX_FUNCTION_DISABLE:
        begin
          if (fdis_locked)
            ev_set[EV_FDIS_REFUSED] = 1'b1;
          else
            next_s.function_disable = wr.data;
        end
        IDX_PORT_CONTROL:         next_s.port_control            = wr.data;
        IDX_EVENT_STATUS:         ev_clr                         = wr.data;
        IDX_EVENT_MASK:           next_s.event_mask              = wr.data & EV_MASK;
        default:                  next_s.kick                    = 1'b0;
      endcase
    end

    // main power-on and hard reset override a same-cycle write to the watchdog registers, the gpio three fan bit and the pin 43 mode field
    if (main_por || hard_reset)
    begin
      next_s.watchdog_time_units  = RST_ZERO;
      next_s.watchdog_count_value = RST_ZERO;
      next_s.watchdog_config      = RST_ZERO;
      next_s.watchdog_control     = RST_ZERO;
      next_s.kick                 = 1'b0;
      if (!main_por)
        next_s.watchdog_control[WDT_KEEP_BIT] = s.watchdog_control[WDT_KEEP_BIT];
      next_s.gpio_data_three[GPIO3_FAN_BIT]                 = 1'b0;
      next_s.pin_forty_three_config[P43_MODE_HI:P43_MODE_LO] = 2'h0;
    end
    ev_set[EV_HARD_RESET] = hard_reset;
    ev_set[EV_MAIN_POR]   = main_por;

    // acknowledge falling while the port is live counts as a port event
    next_s.ack_prev = printer_acknowledge_in;
    if (s.port_control[PCTL_ACTIVATE_BIT])
    begin
      next_s.port_irq = printer_acknowledge_in;
      ev_set[EV_ACK_FALL] = s.ack_prev && !printer_acknowledge_in;
    end
    else
    begin
      next_s.port_irq = 1'b1;
    end

    // set wins over a clear arriving in the same cycle
    next_s.event_status = ((s.event_status & ~ev_clr) | ev_set) & EV_MASK;
  end

  // aresetn stands for the standby power-on reset and restores everything
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= standby_image();
    else
      s <= next_s;
  end

  assign irq               = |(s.event_status & s.event_mask);
  assign parallel_port_irq = s.port_irq;
  assign function_disable  = s.function_disable;
  assign fan_speed_control = s.fan_speed_control;
  assign watchdog_kick     = s.kick;

endmodule // rrm_regbank
